// >>> logic/port_stats.sv
// Purpose: per-port and drop statistics of a three-port switch
// Assumes: frame events are one-cycle pulses on the core clock
// Notes: read answer comes one cycle after the request
`timescale 1ns/1ps
`default_nettype none
module port_stats
   import stat_pkg::*;
#(
   parameter int NP = NUM_PORTS,
   parameter int NC = CNT_PER_PORT
) (
   input wire logic sys_clk_i, // core clock, 25 MHz
   input wire logic rst_n_i, // async reset, active low
   input wire logic max_1536_i, // 1 = long frame limit
   input wire logic [2:0] fdx_i, // port runs full duplex
   input wire rx_evt_t [2:0] rx_evt_i, // rx frame reports
   input wire tx_evt_t [2:0] tx_evt_i, // tx frame reports
   input wire logic [2:0] tx_drop_i, // tx drop pulses
   input wire logic [2:0] rx_drop_i, // rx drop pulses
   input wire rd_cmd_t rd_cmd_i, // indirect read request
   output logic rd_valid_o, // read answer strobe
   output logic [31:0] rd_data_o // read answer word
);
   // one-bit condition widened to an increment
   function automatic logic [10:0] one(input logic c);
      return {10'h000, c};
   endfunction

   // octet amount when the condition holds
   function automatic logic [10:0] amt(input logic c,
                                        input logic [10:0] n);
      return c ? n : 11'h000;
   endfunction

   logic [10:0] inc [NP][NC]; // increment per counter
   logic clr [NP][NC]; // read clear per counter
   logic [PP_CNT_W-1:0] pp_val [NP][NC]; // per-port values
   logic pp_ovf [NP][NC]; // per-port wrap flags
   logic [DROP_CNT_W-1:0] drop_val [2*NP]; // drop values
   logic [10:0] max_len; // active top frame size
   logic pp_hit; // request hits a port block
   logic drop_hit; // request hits a drop counter
   logic [1:0] sel_port; // port of the request
   logic [4:0] sel_idx; // counter of the request
   logic [2:0] sel_drop; // drop counter of the request
   logic [10:0] sel_inc; // event on requested counter
   logic [PP_CNT_W-1:0] sel_val; // value of the requested counter
   rd_state_t st_ff; // registered answer
   rd_state_t nxt_st; // next answer

   // limit follows the max size setting
   always_comb begin
      max_len = max_1536_i ? LEN_MAX_LONG : LEN_MAX_STD; // RL7
   end

   // classify every frame into counter increments
   always_comb begin
      for (int p = 0; p < NP; p++) begin
         logic [10:0] rl; // rx length
         logic [10:0] tl; // tx length
         logic rv; // rx report present
         logic tv; // tx report present
         logic bad; // checksum or symbol error
         logic good; // error free, legal size
         logic legal; // between min and max size
         logic ctrl; // control ethertype
         rl = rx_evt_i[p].len;
         tl = tx_evt_i[p].len;
         rv = rx_evt_i[p].vld;
         tv = tx_evt_i[p].vld;
         bad = !rx_evt_i[p].crc_ok | rx_evt_i[p].sym_err;
         legal = (rl >= LEN_MIN) && (rl <= max_len);
         good = !bad && legal;
         ctrl = rx_evt_i[p].etype == ETYPE_CTRL;
         // rx octets, bad frames counted too
         inc[p][C_RX_LO] = amt(rv & !rx_evt_i[p].hi_prio, rl); // RL5
         inc[p][C_RX_HI] = amt(rv & rx_evt_i[p].hi_prio, rl); // RL5
         // short frames split by checksum
         inc[p][C_RUNT_OK] = one(rv & (rl < LEN_MIN) & !bad); // RL6
         inc[p][C_RUNT_BAD] = one(rv & (rl < LEN_MIN) & bad); // RL6
         // frames above the active limit
         inc[p][C_LONG_OK] = one(rv & (rl > max_len) & !bad); // RL7
         inc[p][C_LONG_BAD] = one(rv & (rl > max_len) & bad); // RL8
         // symbol fault inside a legal frame
         inc[p][C_SYM] = one(rv & legal & rx_evt_i[p].sym_err); // RL9
         // bad checksum, whole bytes or a partial byte
         inc[p][C_CRC] = one(rv & legal & !rx_evt_i[p].crc_ok
                             & !rx_evt_i[p].frac); // RL10
         inc[p][C_FRAC] = one(rv & legal & !rx_evt_i[p].crc_ok
                              & rx_evt_i[p].frac); // RL10
         // control frames by ethertype alone
         inc[p][C_CTRL] = one(rv & ctrl); // RL11
         // pause needs opcode, address, size and checksum
         inc[p][C_PAUSE_RX] = one(rv & ctrl
                                  & (rx_evt_i[p].opcode == OPC_PAUSE)
                                  & rx_evt_i[p].da_pause
                                  & (rl >= LEN_MIN)
                                  & rx_evt_i[p].crc_ok); // RL12
         // good frames by destination kind
         inc[p][C_BC_RX] = one(rv & good & rx_evt_i[p].bcast); // RL13
         inc[p][C_MC_RX] = one(rv & good & rx_evt_i[p].mcast
                               & !rx_evt_i[p].bcast & !ctrl); // RL13
         inc[p][C_UC_RX] = one(rv & good & !rx_evt_i[p].bcast
                               & !rx_evt_i[p].mcast); // RL13
         // length bins, bad frames counted too
         inc[p][C_BIN1] = one(rv & (rl == LEN_MIN)); // RL14
         inc[p][C_BIN1+1] = one(rv & (rl > LEN_MIN)
                                & (rl <= LEN_127)); // RL14
         inc[p][C_BIN1+2] = one(rv & (rl > LEN_127)
                                & (rl <= LEN_255)); // RL14
         inc[p][C_BIN1+3] = one(rv & (rl > LEN_255)
                                & (rl <= LEN_511)); // RL14
         inc[p][C_BIN1+4] = one(rv & (rl > LEN_511)
                                & (rl <= LEN_1023)); // RL14
         inc[p][C_BIN1+5] = one(rv & (rl > LEN_1023)
                                & (rl <= max_len)); // RL14
         // good tx octets, pause frames included
         inc[p][C_TX_LO] = amt(tv & tx_evt_i[p].ok
                               & !tx_evt_i[p].hi_prio, tl); // RL15
         inc[p][C_TX_HI] = amt(tv & tx_evt_i[p].ok
                               & tx_evt_i[p].hi_prio, tl); // RL15
         // each late collision, own pulse
         inc[p][C_LATE] = one(tx_evt_i[p].late_coll); // RL16
         inc[p][C_PAUSE_TX] = one(tv & tx_evt_i[p].pause); // RL17
         // good tx frames by destination kind
         inc[p][C_BC_TX] = one(tv & tx_evt_i[p].ok
                               & tx_evt_i[p].bcast); // RL17
         inc[p][C_MC_TX] = one(tv & tx_evt_i[p].ok
                               & tx_evt_i[p].mcast
                               & !tx_evt_i[p].bcast); // RL17
         inc[p][C_UC_TX] = one(tv & tx_evt_i[p].ok
                               & !tx_evt_i[p].bcast
                               & !tx_evt_i[p].mcast); // RL17
         // first attempt held off by busy medium
         inc[p][C_DEFER] = one(tv & tx_evt_i[p].deferred); // RL18
         // collision totals only in half duplex
         inc[p][C_COLL] = amt(tv & !fdx_i[p],
                              {6'h00, tx_evt_i[p].coll}); // RL19
         inc[p][C_EXCESS] = one(tv & tx_evt_i[p].excess); // RL19
         inc[p][C_ONE] = one(tv & tx_evt_i[p].ok
                             & (tx_evt_i[p].coll == 5'h01)); // RL19
         inc[p][C_MANY] = one(tv & tx_evt_i[p].ok
                              & (tx_evt_i[p].coll > 5'h01)); // RL19
      end
   end

   // decode the indirect read address
   always_comb begin
      pp_hit = rd_cmd_i.req && (rd_cmd_i.addr <= PP_LAST); // RL4
      drop_hit = rd_cmd_i.req && (rd_cmd_i.addr >= DROP_TX1)
                 && (rd_cmd_i.addr <= DROP_LAST); // RL21
      sel_port = rd_cmd_i.addr[6:5]; // RL22
      sel_idx = rd_cmd_i.addr[4:0]; // RL22
      sel_drop = 3'(rd_cmd_i.addr - DROP_TX1); // RL21
      sel_inc = 11'h000;
      sel_val = '0;
      if (pp_hit) begin
         sel_inc = inc[sel_port][sel_idx];
         sel_val = pp_val[sel_port][sel_idx];
      end
   end

   // read of a port counter clears it
   always_comb begin
      for (int p = 0; p < NP; p++) begin
         for (int k = 0; k < NC; k++) begin
            clr[p][k] = pp_hit && (sel_port == 2'(p))
                        && (sel_idx == 5'(k)); // RL23
         end
      end
   end

   // one counter per port and offset
   for (genvar p = 0; p < NP; p++) begin : g_port // RL1
      for (genvar k = 0; k < NC; k++) begin : g_cnt
         stat_cell #(
            .W(PP_CNT_W),
            .IW(LEN_W)
         ) u_cell (
            .sys_clk_i(sys_clk_i),
            .rst_n_i(rst_n_i),
            .inc_i(inc[p][k]),
            .clr_i(clr[p][k]),
            .val_o(pp_val[p][k]),
            .ovf_o(pp_ovf[p][k])
         );
      end
   end

   // drop counters, never cleared by a read
   for (genvar d = 0; d < 2*NP; d++) begin : g_drop
      logic dp; // drop pulse for this counter
      assign dp = (d < NP) ? tx_drop_i[d % NP] : rx_drop_i[d % NP];
      stat_cell #(
         .W(DROP_CNT_W),
         .IW(LEN_W)
      ) u_drop (
         .sys_clk_i(sys_clk_i),
         .rst_n_i(rst_n_i),
         .inc_i(one(dp)),
         .clr_i(1'b0), // RL24
         .val_o(drop_val[d]),
         .ovf_o()
      );
   end

   // build the answer word
   always_comb begin
      nxt_st.vld = rd_cmd_i.req;
      nxt_st.data = WORD_RST;
      if (pp_hit) begin
         nxt_st.data[OVF_BIT] = pp_ovf[sel_port][sel_idx]; // RL2
         // an event in the read cycle makes the snapshot stale
         nxt_st.data[VALID_BIT] = (sel_inc == 11'h000); // RL3
         nxt_st.data[PP_CNT_W-1:0] = pp_val[sel_port][sel_idx]; // RL2
      end else if (drop_hit) begin
         // upper bits stay zero
         nxt_st.data[DROP_CNT_W-1:0] = drop_val[sel_drop]; // RL20
      end
   end

   // answer register
   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign rd_valid_o = st_ff.vld;
   assign rd_data_o = st_ff.data;

   // a port counter read request with no event on that counter in the same cycle
   sequence s_pp_read;
      pp_hit && (sel_inc == 11'h000);
   endsequence

   // the answer strobe one cycle on
   sequence s_answer;
      ##1 rd_valid_o;
   endsequence

   property p_answer;
      @(posedge sys_clk_i) disable iff (!rst_n_i)
      rd_cmd_i.req |-> s_answer;
   endproperty
   a_answer: assert property (p_answer) // RL4
      else $error("read request got no answer");

   property p_clear;
      @(posedge sys_clk_i) disable iff (!rst_n_i)
      (s_pp_read and (rd_cmd_i.addr == PP_BASE1))
      |=> (pp_val[0][0] == '0) && (pp_ovf[0][0] == 1'b0);
   endproperty
   a_clear: assert property (p_clear) // RL23
      else $error("counter not cleared by read");

   property p_stale;
      @(posedge sys_clk_i) disable iff (!rst_n_i)
      (pp_hit && (sel_inc != 11'h000)) |=> !rd_data_o[VALID_BIT];
   endproperty
   a_stale: assert property (p_stale) // RL3
      else $error("valid bit set on a stale count");

   property p_good_valid;
      @(posedge sys_clk_i) disable iff (!rst_n_i)
      s_pp_read |=> rd_data_o[VALID_BIT]
                    && (rd_data_o[29:0] == $past(sel_val));
   endproperty
   a_good_valid: assert property (p_good_valid) // RL2
      else $error("per-port word wrong");

   property p_port2;
      @(posedge sys_clk_i) disable iff (!rst_n_i)
      (rd_cmd_i.req && (rd_cmd_i.addr == PP_BASE2 + 9'h00E))
      |=> rd_data_o[29:0] == $past(pp_val[1][C_BIN1]);
   endproperty
   a_port2: assert property (p_port2) // RL22
      else $error("port two block misplaced");

   property p_drop_keep;
      @(posedge sys_clk_i) disable iff (!rst_n_i)
      (drop_hit && (rd_cmd_i.addr == DROP_RX1) && !rx_drop_i[0])
      |=> $stable(drop_val[3]) && (rd_data_o[31:16] == 16'h0000);
   endproperty
   a_drop_keep: assert property (p_drop_keep) // RL24
      else $error("drop counter changed by read");

   property p_bin64;
      @(posedge sys_clk_i) disable iff (!rst_n_i)
      (rx_evt_i[0].vld && (rx_evt_i[0].len == LEN_MIN)
       && !clr[0][C_BIN1])
      |=> pp_val[0][C_BIN1] == $past(pp_val[0][C_BIN1]) + 30'h1;
   endproperty
   a_bin64: assert property (p_bin64) // RL14
      else $error("minimum length bin missed a frame");

   property p_octets;
      @(posedge sys_clk_i) disable iff (!rst_n_i)
      (rx_evt_i[0].vld && !rx_evt_i[0].hi_prio && !clr[0][C_RX_LO])
      |=> pp_val[0][C_RX_LO] == $past(pp_val[0][C_RX_LO])
          + 30'($past(rx_evt_i[0].len));
   endproperty
   a_octets: assert property (p_octets) // RL5
      else $error("rx octets not accumulated");

   property p_unmapped;
      @(posedge sys_clk_i) disable iff (!rst_n_i)
      (rd_cmd_i.req && !pp_hit && !drop_hit)
      |=> rd_data_o == WORD_RST;
   endproperty
   a_unmapped: assert property (p_unmapped) // RL4
      else $error("unmapped read returned data");
endmodule
`default_nettype wire

// >>> logic/stat_pkg.sv
// Purpose: shared constants and carriers of the port statistics block
// Assumes: three switch ports, 32 counters each, six drop counters
// Notes: counters are reached through an indirect read port
// Behaviour
// (RL1) 32 counters per port, two groups
// (RL2) word: overflow bit 31, count 29..0
// (RL3) bit 30 set only for trusted counts
// (RL4) port blocks at 0x00, 0x20, 0x40
// (RL5) rx octets by priority, bad included
// (RL6) runts by good or bad checksum
// (RL7) too long frames with good checksum
// (RL8) too long frames with any error
// (RL9) legal size frames with bad symbol
// (RL10) legal bad checksum, whole or partial byte
// (RL11) count control ethertype frames
// (RL12) pause frames fully qualified only
// (RL13) good rx broadcast, multicast, unicast
// (RL14) rx length bins, bad included
// (RL15) tx good octets by priority
// (RL16) late collisions past 512 bit times
// (RL17) tx pause and good cast counts
// (RL18) tx frames that waited for medium
// (RL19) four collision counters
// (RL20) drop word: 16-bit count, upper zero
// (RL21) tx drops 0x100.., rx drops 0x103..
// (RL22) same layout for every port block
// (RL23) reading a port counter clears it
// (RL24) drop counters never clear on read
// (RL25) host selects table then writes offset; the host model sends both as one 9-bit address per read
// (RL26) host rereads when valid bit clear
package stat_pkg;
   localparam int NUM_PORTS = 3;
   localparam int CNT_PER_PORT = 32;
   localparam int TOTAL_COUNTERS = 34; // unused; the block holds 3 x 32 port counters plus six drops
   localparam int PP_CNT_W = 30;
   localparam int DROP_CNT_W = 16;
   localparam int LEN_W = 11;
   localparam int ADDR_W = 9;
   localparam int OVF_BIT = 31;
   localparam int VALID_BIT = 30;
   localparam logic [8:0] PP_BASE1 = 9'h000;
   localparam logic [8:0] PP_BASE2 = 9'h020;
   localparam logic [8:0] PP_BASE3 = 9'h040;
   localparam logic [8:0] PP_LAST = 9'h05F;
   localparam logic [8:0] DROP_TX1 = 9'h100;
   localparam logic [8:0] DROP_RX1 = 9'h103;
   localparam logic [8:0] DROP_LAST = 9'h105;
   localparam logic [31:0] WORD_RST = 32'h00000000;
   // counter offsets inside a port block
   localparam int C_RX_LO = 'h00, C_RX_HI = 'h01, C_RUNT_OK = 'h02;
   localparam int C_RUNT_BAD = 'h03, C_LONG_OK = 'h04;
   localparam int C_LONG_BAD = 'h05, C_SYM = 'h06, C_CRC = 'h07;
   localparam int C_FRAC = 'h08, C_CTRL = 'h09, C_PAUSE_RX = 'h0A;
   localparam int C_BC_RX = 'h0B, C_MC_RX = 'h0C, C_UC_RX = 'h0D;
   localparam int C_BIN1 = 'h0E, C_TX_LO = 'h14, C_TX_HI = 'h15;
   localparam int C_LATE = 'h16, C_PAUSE_TX = 'h17, C_BC_TX = 'h18;
   localparam int C_MC_TX = 'h19, C_UC_TX = 'h1A, C_DEFER = 'h1B;
   localparam int C_COLL = 'h1C, C_EXCESS = 'h1D, C_ONE = 'h1E;
   localparam int C_MANY = 'h1F;
   // frame length limits in octets
   localparam logic [10:0] LEN_MIN = 11'h040;
   localparam logic [10:0] LEN_127 = 11'h07F;
   localparam logic [10:0] LEN_255 = 11'h0FF;
   localparam logic [10:0] LEN_511 = 11'h1FF;
   localparam logic [10:0] LEN_1023 = 11'h3FF;
   localparam logic [10:0] LEN_MAX_STD = 11'h5F2;
   localparam logic [10:0] LEN_MAX_LONG = 11'h600;
   localparam logic [15:0] ETYPE_CTRL = 16'h8808;
   localparam logic [15:0] OPC_PAUSE = 16'h0001;

   // one received frame, reported once at its end
   typedef struct packed {
      logic vld;
      logic hi_prio;
      logic crc_ok;
      logic sym_err;
      logic frac;
      logic bcast;
      logic mcast;
      logic da_pause;
      logic [15:0] etype;
      logic [15:0] opcode;
      logic [10:0] len;
   } rx_evt_t;

   // one transmit attempt sequence, reported once at its end
   typedef struct packed {
      logic vld;
      logic hi_prio;
      logic ok;
      logic bcast;
      logic mcast;
      logic pause;
      logic deferred;
      logic excess;
      logic late_coll;
      logic [4:0] coll;
      logic [10:0] len;
   } tx_evt_t;

   typedef struct packed {
      logic req;
      logic [8:0] addr;
   } rd_cmd_t;

   typedef struct packed {
      logic vld;
      logic [31:0] data;
   } rd_state_t;
endpackage

// >>> logic/stat_cell.sv
// Purpose: one statistics counter with overflow flag and clear
// Assumes: increment and clear arrive on the system clock
// Notes: an increment in the clear cycle is kept, not lost
`timescale 1ns/1ps
`default_nettype none
module stat_cell #(
   parameter int W = 30,
   parameter int IW = 11
) (
   input wire logic sys_clk_i, // core clock
   input wire logic rst_n_i, // async reset, active low
   input wire logic [IW-1:0] inc_i, // amount to add
   input wire logic clr_i, // clear before adding
   output logic [W-1:0] val_o, // counter value
   output logic ovf_o // sticky wrap flag
);
   typedef struct packed {
      logic ovf;
      logic [W-1:0] cnt;
   } cell_t;

   cell_t st_ff; // registered state
   cell_t nxt_st; // next state
   logic [W:0] sum; // count plus increment, with carry

   // clear first, then add so the event wins
   always_comb begin
      nxt_st = st_ff;
      if (clr_i) begin
         nxt_st = '0;
      end
      sum = {1'b0, nxt_st.cnt} + (W+1)'(inc_i);
      nxt_st.cnt = sum[W-1:0];
      nxt_st.ovf = nxt_st.ovf | sum[W];
   end

   // state register
   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign val_o = st_ff.cnt;
   assign ovf_o = st_ff.ovf;
endmodule
`default_nettype wire

// >>> testbench/host_model.sv
// Purpose: host side of the counter read port, issues indirect reads
// Assumes: tasks are entered at a falling clock edge
// Notes: after a read the address is inverted so nothing stale matches
`timescale 1ns/1ps
`default_nettype none
module host_model
   import stat_pkg::*;
(
   input wire logic sys_clk_i, // core clock
   input wire logic rd_valid_i, // answer strobe
   input wire logic [31:0] rd_data_i, // answer word
   output var rd_cmd_t rd_cmd_o // read request
);
   // idle request at start
   initial begin
      rd_cmd_o = '{req: 1'b0, addr: 9'h1FF};
   end

   // one read: request for one cycle, answer taken in the next one
   task automatic read_word(input logic [8:0] a, output logic v,
         output logic [31:0] d);
      rd_cmd_o = '{req: 1'b1, addr: a};
      @(negedge sys_clk_i);
      v = rd_valid_i;
      d = rd_data_i;
      rd_cmd_o = '{req: 1'b0, addr: ~a};
      // idle cycle so a following read never drives in the same step
      @(negedge sys_clk_i);
   endtask

   // per-port read, tried again while the trust flag is clear
   task automatic read_trusted(input logic [8:0] a, output logic v,
         output logic [31:0] d);
      int n;
      n = 0;
      read_word(a, v, d);
      // retry bounded so a stuck flag cannot hang the host
      while (d[VALID_BIT] !== 1'b1 && n < 4) begin
         n++;
         read_word(a, v, d);
      end
   endtask
endmodule
`default_nettype wire

// >>> testbench/testbench.sv
// Purpose: self-checking bench of the port statistics block
// Assumes: inputs change at the falling clock edge only
// Notes: table cases run on the third port to keep the first two clean
`timescale 1ns/1ps
`default_nettype none
module testbench
   import stat_pkg::*;
;
   logic sys_clk; // core clock
   logic rst_n; // reset, active low
   logic max_1536; // long frame limit
   logic [2:0] fdx; // full duplex per port
   rx_evt_t [2:0] rx_ev; // rx reports
   tx_evt_t [2:0] tx_ev; // tx reports
   logic [2:0] tx_drop; // tx drop pulses
   logic [2:0] rx_drop; // rx drop pulses
   rd_cmd_t rd_cmd; // read request from host
   logic rd_valid; // answer strobe
   logic [31:0] rd_data; // answer word
   int failures; // mismatches seen
   int num_checks; // comparisons made
   int cycles; // clock cycles run
   logic v; // last answer strobe
   logic [31:0] d; // last answer word

   port_stats dut_u (
      .sys_clk_i(sys_clk), .rst_n_i(rst_n), .max_1536_i(max_1536),
      .fdx_i(fdx), .rx_evt_i(rx_ev), .tx_evt_i(tx_ev),
      .tx_drop_i(tx_drop), .rx_drop_i(rx_drop), .rd_cmd_i(rd_cmd),
      .rd_valid_o(rd_valid), .rd_data_o(rd_data)
   );

   host_model host_u (
      .sys_clk_i(sys_clk), .rd_valid_i(rd_valid), .rd_data_i(rd_data),
      .rd_cmd_o(rd_cmd)
   );

   // 25 MHz clock
   always #20 sys_clk = ~sys_clk;

   // hang guard: far above the expected run of under two hundred cycles
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 3000) begin
         failures++;
         tally_and_finish();
      end
   end

   // compare and report
   task automatic chk(input logic [32:0] got, input logic [32:0] exp);
      num_checks++;
      if (got !== exp) begin
         failures++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // read a word and expect a strobe plus the given value
   task automatic rdw(input logic [8:0] a, input logic [31:0] e);
      host_u.read_word(a, v, d);
      chk({v, d}, {1'b1, e});
   endtask

   // one-cycle event report on a port, then an idle cycle
   task automatic pulse(input int p, input rx_evt_t r, input tx_evt_t t);
      rx_ev[p] = r;
      tx_ev[p] = t;
      @(negedge sys_clk);
      rx_ev[p] = '0;
      tx_ev[p] = '0;
      @(negedge sys_clk);
   endtask

   // rx frame on the third port, then read one of its counters
   task automatic rxc(input logic [7:0] f, input logic [15:0] et,
         input logic [15:0] op, input logic [10:0] ln, input logic mx,
         input logic [4:0] off, input logic [29:0] e);
      max_1536 = mx;
      pulse(2, rx_evt_t'({f, et, op, ln}), '0);
      rdw(PP_BASE3 | {4'h0, off}, {2'b01, e});
   endtask

   // tx report on the third port, then read one of its counters
   task automatic txc(input logic [8:0] f, input logic [4:0] cl,
         input logic [10:0] ln, input logic fd, input logic [4:0] off,
         input logic [29:0] e);
      fdx = {fd, 2'b11};
      pulse(2, '0, tx_evt_t'({f, cl, ln}));
      rdw(PP_BASE3 | {4'h0, off}, {2'b01, e});
   endtask

   // counts, verdict and end of run
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   // main sequence
   initial begin
      sys_clk = 1'b0;
      rst_n = 1'b0;
      max_1536 = 1'b0;
      fdx = 3'h7;
      rx_ev = '0;
      tx_ev = '0;
      tx_drop = 3'h0;
      rx_drop = 3'h0;
      failures = 0;
      num_checks = 0;
      cycles = 0;
      repeat (6) @(negedge sys_clk);
      rst_n = 1'b1;
      @(negedge sys_clk);
      rdw(9'h000, 32'h4000_0000);
      rdw(9'h100, 32'h0000_0000);
      $display("test reset done");
      // first and second port blocks
      pulse(0, rx_evt_t'({8'hA4, 32'h0, 11'h040}), '0);
      rdw(9'h00B, 32'h4000_0001);
      pulse(0, rx_evt_t'({8'h80, 32'h0, 11'h040}), '0);
      rdw(9'h000, 32'h4000_0080);
      rdw(9'h00E, 32'h4000_0002);
      rdw(9'h000, 32'h4000_0000);
      pulse(1, rx_evt_t'({8'hE0, 32'h0, 11'h050}), '0);
      rdw(9'h021, 32'h4000_0050);
      rdw(9'h02F, 32'h4000_0001);
      rdw(9'h02D, 32'h4000_0001);
      rdw(9'h001, 32'h4000_0000);
      $display("test port blocks done");
      // rx classification on the third port
      rxc(8'hA0, 16'h0, 16'h0, 11'h028, 1'b0, 5'h02, 30'h1);
      rxc(8'h80, 16'h0, 16'h0, 11'h028, 1'b0, 5'h03, 30'h1);
      rxc(8'hA0, 16'h0, 16'h0, 11'h5FA, 1'b0, 5'h04, 30'h1);
      rxc(8'hA0, 16'h0, 16'h0, 11'h5FA, 1'b1, 5'h13, 30'h1);
      rxc(8'h80, 16'h0, 16'h0, 11'h600, 1'b0, 5'h05, 30'h1);
      rxc(8'hB0, 16'h0, 16'h0, 11'h5F0, 1'b0, 5'h06, 30'h1);
      rxc(8'h80, 16'h0, 16'h0, 11'h5F2, 1'b0, 5'h07, 30'h1);
      rxc(8'h88, 16'h0, 16'h0, 11'h040, 1'b0, 5'h08, 30'h1);
      rxc(8'hA0, 16'h8808, 16'h0, 11'h040, 1'b0, 5'h09, 30'h1);
      rxc(8'hA1, 16'h8808, 16'h1, 11'h040, 1'b0, 5'h0A, 30'h1);
      rxc(8'hA0, 16'h8808, 16'h1, 11'h040, 1'b0, 5'h0A, 30'h0);
      rxc(8'h81, 16'h8808, 16'h1, 11'h040, 1'b0, 5'h0A, 30'h0);
      rxc(8'hA2, 16'h0, 16'h0, 11'h040, 1'b0, 5'h0C, 30'h1);
      rxc(8'hA2, 16'h8808, 16'h0, 11'h040, 1'b0, 5'h0C, 30'h0);
      rxc(8'hA0, 16'h0, 16'h0, 11'h041, 1'b0, 5'h0D, 30'h5);
      rxc(8'h80, 16'h0, 16'h0, 11'h0FF, 1'b0, 5'h10, 30'h1);
      rxc(8'h80, 16'h0, 16'h0, 11'h1FF, 1'b0, 5'h11, 30'h1);
      rxc(8'h80, 16'h0, 16'h0, 11'h200, 1'b0, 5'h12, 30'h1);
      $display("test rx counters done");
      // tx classification on the third port
      txc(9'h160, 5'h00, 11'h040, 1'b1, 5'h14, 30'h040);
      txc(9'h1E0, 5'h00, 11'h5EE, 1'b1, 5'h15, 30'h5EE);
      txc(9'h160, 5'h00, 11'h040, 1'b1, 5'h18, 30'h3);
      txc(9'h150, 5'h00, 11'h040, 1'b1, 5'h19, 30'h1);
      txc(9'h140, 5'h00, 11'h040, 1'b1, 5'h1A, 30'h1);
      txc(9'h120, 5'h00, 11'h040, 1'b1, 5'h18, 30'h0);
      txc(9'h108, 5'h00, 11'h040, 1'b1, 5'h17, 30'h1);
      txc(9'h104, 5'h00, 11'h040, 1'b1, 5'h1B, 30'h1);
      txc(9'h102, 5'h10, 11'h040, 1'b1, 5'h1D, 30'h1);
      txc(9'h140, 5'h01, 11'h040, 1'b1, 5'h1E, 30'h1);
      txc(9'h140, 5'h03, 11'h040, 1'b1, 5'h1F, 30'h1);
      txc(9'h100, 5'h03, 11'h040, 1'b0, 5'h1C, 30'h3);
      txc(9'h100, 5'h03, 11'h040, 1'b1, 5'h1C, 30'h0);
      txc(9'h001, 5'h00, 11'h040, 1'b1, 5'h16, 30'h1);
      $display("test tx counters done");
      // read colliding with an event on the same counter
      host_u.read_word(9'h04E, v, d);
      fork
         pulse(2, rx_evt_t'({8'hA0, 32'h0, 11'h040}), '0);
         host_u.read_word(9'h04E, v, d);
      join
      chk({v, d}, {1'b1, 32'h0000_0000});
      fork
         pulse(2, rx_evt_t'({8'hA0, 32'h0, 11'h040}), '0);
         host_u.read_trusted(9'h04E, v, d);
      join
      chk({v, d}, {1'b1, 32'h4000_0001});
      $display("test valid flag done");
      // drop counters and unmapped space
      tx_drop = 3'h2;
      repeat (3) @(negedge sys_clk);
      tx_drop = 3'h0;
      rx_drop = 3'h4;
      @(negedge sys_clk);
      rx_drop = 3'h0;
      rdw(9'h101, 32'h0000_0003);
      rdw(9'h101, 32'h0000_0003);
      rdw(9'h105, 32'h0000_0001);
      rdw(9'h100, 32'h0000_0000);
      rdw(9'h103, 32'h0000_0000);
      rdw(9'h080, 32'h0000_0000);
      rdw(9'h1FF, 32'h0000_0000);
      $display("test drop counters done");
      tally_and_finish();
   end
endmodule
`default_nettype wire
